// *** tb/rtb_pin_partner.sv ***
// Far-side model of the timer pin: an event source that yields when the block drives.
`timescale 1ns/1ps

module rtb_pin_partner (
    input  wire logic hclk,
    input  wire logic pin_oe,
    input  wire logic pin_out,
    output logic      pin_level
);
    logic ext_level = 1'b0;

    // The block's driver wins whenever its enable is high; a released pin shows the source.
    assign pin_level = pin_oe ? pin_out : ext_level;

    // Each level is held past one instruction cycle, otherwise a sample could miss it.
    task automatic pulse(input int hold);
        repeat (hold) @(posedge hclk);
        ext_level <= 1'b1;
        repeat (hold) @(posedge hclk);
        ext_level <= 1'b0;
    endtask : pulse
endmodule : rtb_pin_partner

// *** tb/test_reload_timer_pwm_event_counter.sv ***
// Self-checking bench of the reload timer with its pin partner.
`timescale 1ns/1ps

module test_reload_timer_pwm_event_counter;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_level;
    logic        pin_out;
    logic        pin_oe;
    logic        irq;
    logic [31:0] rd;
    logic [7:0]  r;
    logic [7:0]  n;
    int          miscompares = 0;
    int          comparisons = 0;
    int          seed = 32'h6ad6;

    rtb_timer u_rtb_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_b_pin_in(pin_level),
        .timer_b_pin_out(pin_out), .timer_b_pin_oe(pin_oe), .irq(irq));
    rtb_pin_partner u_rtb_pin_partner (.hclk(hclk), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_level(pin_level));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] ctrl(logic [2:0] m, logic run, logic pnd, logic en);
        return {m, run, pnd, en, rtb_pkg::CTRL_RSVD};
    endfunction : ctrl

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Entered just after a rising edge; every bus signal changes by non-blocking assignment.
    task automatic bus(input logic [7:0] addr, input logic wr, input logic [7:0] wd);
        haddr  <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        bus(addr, 1'b0, 8'h00);
        check(rd, {24'h0, exp});
        check({31'h0, hresp}, 32'h0);
    endtask : rchk

    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 3000 && irq !== lvl; i++) @(posedge hclk);
        check({31'h0, irq}, {31'h0, lvl});
    endtask : wait_irq

    task automatic complete_run();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    // The whole sequence needs at most about 12500 cycles; over six times that means a hang.
    initial begin
        repeat (80000) @(posedge hclk);
        miscompares++;
        complete_run();
    end

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b1;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(rtb_pkg::ADDR_CTRL, 8'h00);
        rchk(rtb_pkg::ADDR_CNT_HI, 8'hff);
        rchk(rtb_pkg::ADDR_RELOAD_LO, 8'h00);
        bus(rtb_pkg::ADDR_CTRL, 1'b1, 8'h03);
        rchk(rtb_pkg::ADDR_CTRL, 8'h00);
        rchk(8'h20, 8'h00);
        repeat (4) begin
            r = 8'($random(seed));
            bus(rtb_pkg::ADDR_RELOAD_HI, 1'b1, r);
            bus(rtb_pkg::ADDR_CNT_LO, 1'b1, ~r);
            rchk(rtb_pkg::ADDR_RELOAD_HI, r);
            rchk(rtb_pkg::ADDR_CNT_LO, ~r);
        end
        // Toggling PWM, pin starting high.
        r = 8'(3 + ($random(seed) & 7));
        n = r + 8'h02;
        bus(rtb_pkg::ADDR_PORT_DIR, 1'b1, 8'h04);
        bus(rtb_pkg::ADDR_PORT_OUT, 1'b1, 8'h04);
        check({31'h0, pin_oe}, 32'h1);
        bus(rtb_pkg::ADDR_CNT_LO, 1'b1, 8'h02);
        bus(rtb_pkg::ADDR_CNT_HI, 1'b1, 8'h00);
        bus(rtb_pkg::ADDR_RELOAD_LO, 1'b1, r);
        bus(rtb_pkg::ADDR_RELOAD_HI, 1'b1, 8'h00);
        bus(rtb_pkg::ADDR_GLOBAL_IRQ, 1'b1, 8'h01);
        bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(rtb_pkg::MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b1));
        wait_irq(1'b1);
        check({31'h0, pin_out}, 32'h0);
        rchk(rtb_pkg::ADDR_CNT_LO, r);
        rchk(rtb_pkg::ADDR_CTRL, ctrl(rtb_pkg::MODE_PWM_TOGGLE, 1'b1, 1'b1, 1'b1));
        bus(rtb_pkg::ADDR_RELOAD_LO, 1'b1, n);
        bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(rtb_pkg::MODE_PWM_TOGGLE, 1'b1, 1'b1, 1'b0));
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(rtb_pkg::MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b1));
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        wait_irq(1'b1);
        check({31'h0, pin_out}, 32'h1);
        rchk(rtb_pkg::ADDR_CNT_LO, n);
        bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(rtb_pkg::MODE_PWM_PLAIN, 1'b1, 1'b0, 1'b1));
        // The request left over from the last toggle needs two edges to drop.
        repeat (2) @(posedge hclk);
        wait_irq(1'b1);
        check({31'h0, pin_out}, 32'h1);
        rchk(rtb_pkg::ADDR_CNT_LO, n);
        // Event counting on both edge kinds; n events reach zero, one more underflows.
        bus(rtb_pkg::ADDR_PORT_DIR, 1'b1, 8'h00);
        for (int k = 0; k < 2; k++) begin
            n = 8'(1 + ($random(seed) & 1));
            bus(rtb_pkg::ADDR_CTRL, 1'b1, 8'h00);
            bus(rtb_pkg::ADDR_CNT_LO, 1'b1, n);
            bus(rtb_pkg::ADDR_RELOAD_LO, 1'b1, 8'h07);
            bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(3'(k), 1'b1, 1'b0, 1'b0));
            repeat (n) u_rtb_pin_partner.pulse(250);
            repeat (250) @(posedge hclk);
            rchk(rtb_pkg::ADDR_CNT_LO, 8'h00);
            rchk(rtb_pkg::ADDR_CTRL, ctrl(3'(k), 1'b1, 1'b0, 1'b0));
            u_rtb_pin_partner.pulse(250);
            repeat (250) @(posedge hclk);
            rchk(rtb_pkg::ADDR_CNT_LO, 8'h07);
            rchk(rtb_pkg::ADDR_CTRL, ctrl(3'(k), 1'b1, 1'b1, 1'b0));
        end
        // Capture on both edge kinds, then an underflow with the run bit left clear.
        for (int k = 2; k < 4; k++) begin
            bus(rtb_pkg::ADDR_CTRL, 1'b1, 8'h00);
            bus(rtb_pkg::ADDR_CNT_HI, 1'b1, 8'hff);
            bus(rtb_pkg::ADDR_RELOAD_HI, 1'b1, 8'h00);
            bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(3'(k), 1'b0, 1'b0, 1'b0));
            u_rtb_pin_partner.pulse(250);
            repeat (250) @(posedge hclk);
            rchk(rtb_pkg::ADDR_RELOAD_HI, 8'hff);
            rchk(rtb_pkg::ADDR_CTRL, ctrl(3'(k), 1'b0, 1'b1, 1'b0));
            bus(rtb_pkg::ADDR_CNT_HI, 1'b1, 8'h00);
            bus(rtb_pkg::ADDR_CNT_LO, 1'b1, 8'h01);
            repeat (600) @(posedge hclk);
            rchk(rtb_pkg::ADDR_CTRL, ctrl(3'(k), 1'b1, 1'b1, 1'b0));
        end
        // An undefined mode code must leave the counter idle.
        bus(rtb_pkg::ADDR_CTRL, 1'b1, ctrl(3'h6, 1'b1, 1'b0, 1'b0));
        bus(rtb_pkg::ADDR_CNT_LO, 1'b1, 8'h05);
        repeat (400) @(posedge hclk);
        rchk(rtb_pkg::ADDR_CNT_LO, 8'h05);
        complete_run();
    end
endmodule : test_reload_timer_pwm_event_counter

// *** verilog/rtb_edge_detect.sv ***
// Pin edge detector sampled at the instruction clock rate.
`timescale 1ns/1ps

module rtb_edge_detect (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic sample_en,
    input  wire logic pin,
    input  wire logic fall_sel,
    output logic      pin_edge
);

    logic prev;
    logic primed;

    // The first sample only primes the history, so a pin already high at reset
    // is not taken for a rising edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev     <= 1'b0;
            primed   <= 1'b0;
            pin_edge <= 1'b0;
        end else begin
            pin_edge <= 1'b0;
            if (sample_en) begin
                prev     <= pin;
                primed   <= 1'b1;
                pin_edge <= primed & (fall_sel ? (prev & ~pin) : (~prev & pin));
            end
        end
    end

endmodule : rtb_edge_detect

// *** verilog/rtb_pkg.sv ***
// Shared constants, register map and types of the reload timer block.
package rtb_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned INSTR_CYCLE_NS  = 1000;
    localparam int unsigned INSTR_DIV       = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  INSTR_DIV_LAST  = 8'(INSTR_DIV - 1);
    localparam logic [7:0]  INSTR_DIV_ZERO  = 8'h00;

    // ************************************************************
    // Register map, byte addresses on the bus
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_CNT_LO      = 8'h04;
    localparam logic [7:0] ADDR_CNT_HI      = 8'h08;
    localparam logic [7:0] ADDR_RELOAD_LO   = 8'h0c;
    localparam logic [7:0] ADDR_RELOAD_HI   = 8'h10;
    localparam logic [7:0] ADDR_PORT_DIR    = 8'h14;
    localparam logic [7:0] ADDR_PORT_OUT    = 8'h18;
    localparam logic [7:0] ADDR_GLOBAL_IRQ  = 8'h1c;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int unsigned PIN_BIT         = 2;
    localparam int unsigned GLOBAL_EN_BIT   = 0;
    localparam logic [15:0] COUNTER_RESET   = 16'hffff;
    localparam logic [15:0] RELOAD_RESET    = 16'h0000;
    localparam logic [15:0] COUNTER_ZERO    = 16'h0000;
    localparam logic [15:0] COUNTER_STEP    = 16'h0001;
    localparam logic [7:0]  PORT_RESET      = 8'h00;
    localparam logic [1:0]  CTRL_RSVD       = 2'h0;
    localparam logic [2:0]  MODE_RESET      = 3'h0;

    // ************************************************************
    // Mode codes
    // ************************************************************
    localparam logic [2:0] MODE_EVT_RISE    = 3'h0;
    localparam logic [2:0] MODE_EVT_FALL    = 3'h1;
    localparam logic [2:0] MODE_CAP_RISE    = 3'h2;
    localparam logic [2:0] MODE_CAP_FALL    = 3'h3;
    localparam logic [2:0] MODE_PWM_PLAIN   = 3'h4;
    localparam logic [2:0] MODE_PWM_TOGGLE  = 3'h5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [2:0] mode;
        logic       run;
        logic       pending;
        logic       irq_en;
        logic [1:0] rsvd;
    } rtb_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } rtb_req_t;

endpackage : rtb_pkg

// *** verilog/rtb_timer.sv ***
// Reload timer with PWM, event counter and capture modes behind an AHB-Lite slave.
`timescale 1ns/1ps

// Behaviour
// RULE1: control holds mode, run, pending, enable bits
// RULE2: run bit starts and stops outside capture
// RULE3: capture mode: run bit flags underflow
// RULE4: pending bit reads one while pending
// RULE5: enable bit gates the timer interrupt
// RULE6: mode codes select event, PWM, capture
// RULE7: PWM decrements per instruction clock, reloads
// RULE8: toggle option inverts pin each underflow
// RULE9: reload underflow sets pending, interrupt follows
// RULE10: interrupt needs pending, enable and global enable
// RULE11: software alternates reload value each underflow
// RULE12: software clears pending flag itself
// RULE13: software PWM start order is fixed
// RULE14: software clears flags before enabling interrupts
// RULE15: event mode counts selected pin edges
// RULE16: external pulses last one instruction cycle
// RULE17: pin sampled at instruction clock rate
// RULE18: software sets pin as input first
// RULE19: underflow 0000 to ffff; reset values
// RULE20: capture edge copies counter, sets pending
// RULE21: capture mode counts regardless of run
// RULE22: counter and reload split into bytes
// RULE23: reserved bits zero; instruction clock enable pulse
module rtb_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timer_b_pin_in,
    output logic             timer_b_pin_out,
    output logic             timer_b_pin_oe,
    output logic             irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    rtb_pkg::rtb_ctrl_t ctrl;
    rtb_pkg::rtb_req_t  req;
    rtb_pkg::rtb_ctrl_t wctrl;
    logic [15:0]        timer_b_counter;
    logic [15:0]        reload_capture_reg;
    logic [7:0]         port_direction_reg;
    logic [7:0]         port_output_reg;
    logic               global_irq_en;
    logic [7:0]         instr_div;
    logic               instr_en;
    logic               rd_pend;
    logic               pin_edge;
    logic [7:0]         wdata;
    logic               wr_en;
    logic               wr_ctrl;
    logic               wr_cnt_lo;
    logic               wr_cnt_hi;
    logic               wr_rl_lo;
    logic               wr_rl_hi;
    logic               wr_pdir;
    logic               wr_pout;
    logic               wr_glob;
    logic               rd_accept;
    logic               is_evt;
    logic               is_pwm;
    logic               is_cap;
    logic               tick;
    logic               underflow;
    logic               reload_uf;
    logic               capture;
    logic [31:0]        next_rdata;

    // ************************************************************
    // Instruction clock enable
    // ************************************************************
    // One pulse per instruction cycle; all counting is gated by it so the
    // block stays in the single bus clock domain.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_div <= rtb_pkg::INSTR_DIV_ZERO;
            instr_en  <= 1'b0;
        end else begin
            instr_en <= (instr_div == rtb_pkg::INSTR_DIV_LAST); // see RULE23
            if (instr_div == rtb_pkg::INSTR_DIV_LAST) begin
                instr_div <= rtb_pkg::INSTR_DIV_ZERO;
            end else begin
                instr_div <= instr_div + 8'h01;
            end
        end
    end

    // The pin is only looked at on instruction enables, so transitions
    // faster than half the instruction rate are lost.
    rtb_edge_detect u_edge (                                  // see RULE17
        .hclk      (hclk),
        .hresetn   (hresetn),
        .sample_en (instr_en),
        .pin       (timer_b_pin_in),
        .fall_sel  (ctrl.mode[0]),
        .pin_edge  (pin_edge)
    );

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    assign rd_accept = hready & hsel & htrans[1] & ~hwrite;
    assign wr_en     = req.valid & req.write;
    assign wdata     = hwdata[7:0];
    assign wctrl     = rtb_pkg::rtb_ctrl_t'(wdata);
    assign wr_ctrl   = wr_en & (req.addr == rtb_pkg::ADDR_CTRL);
    assign wr_cnt_lo = wr_en & (req.addr == rtb_pkg::ADDR_CNT_LO);
    assign wr_cnt_hi = wr_en & (req.addr == rtb_pkg::ADDR_CNT_HI);
    assign wr_rl_lo  = wr_en & (req.addr == rtb_pkg::ADDR_RELOAD_LO);
    assign wr_rl_hi  = wr_en & (req.addr == rtb_pkg::ADDR_RELOAD_HI);
    assign wr_pdir   = wr_en & (req.addr == rtb_pkg::ADDR_PORT_DIR);
    assign wr_pout   = wr_en & (req.addr == rtb_pkg::ADDR_PORT_OUT);
    assign wr_glob   = wr_en & (req.addr == rtb_pkg::ADDR_GLOBAL_IRQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else if (hready) begin
            req.valid <= hsel & htrans[1];
            req.write <= hwrite;
            req.addr  <= haddr[7:0];
        end
    end

    // Reads take one wait state so that a write in the previous data phase
    // is always visible and read data can come from a register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_accept) begin
                rd_pend   <= 1'b1;
                hreadyout <= 1'b0;
            end else if (rd_pend) begin
                rd_pend   <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (req.addr)
            rtb_pkg::ADDR_CTRL:       next_rdata[7:0] = ctrl;            // see RULE4
            rtb_pkg::ADDR_CNT_LO:     next_rdata[7:0] = timer_b_counter[7:0];
            rtb_pkg::ADDR_CNT_HI:     next_rdata[7:0] = timer_b_counter[15:8];
            rtb_pkg::ADDR_RELOAD_LO:  next_rdata[7:0] = reload_capture_reg[7:0];
            rtb_pkg::ADDR_RELOAD_HI:  next_rdata[7:0] = reload_capture_reg[15:8];
            rtb_pkg::ADDR_PORT_DIR:   next_rdata[7:0] = port_direction_reg;
            rtb_pkg::ADDR_PORT_OUT:   next_rdata[7:0] = port_output_reg;
            rtb_pkg::ADDR_GLOBAL_IRQ: next_rdata[rtb_pkg::GLOBAL_EN_BIT] = global_irq_en;
            default:                  next_rdata = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Mode decode and counting events
    // ************************************************************
    assign is_evt = (ctrl.mode == rtb_pkg::MODE_EVT_RISE)              // see RULE6
                  | (ctrl.mode == rtb_pkg::MODE_EVT_FALL);
    assign is_pwm = (ctrl.mode == rtb_pkg::MODE_PWM_PLAIN)
                  | (ctrl.mode == rtb_pkg::MODE_PWM_TOGGLE);
    assign is_cap = (ctrl.mode == rtb_pkg::MODE_CAP_RISE)
                  | (ctrl.mode == rtb_pkg::MODE_CAP_FALL);

    // Codes 110 and 111 are undefined and leave the counter idle.
    assign tick = (is_pwm & ctrl.run & instr_en)                       // see RULE7
                | (is_evt & ctrl.run & pin_edge)                       // see RULE15
                | (is_cap & instr_en);                                 // see RULE21
    assign underflow = tick & (timer_b_counter == rtb_pkg::COUNTER_ZERO); // see RULE19
    assign reload_uf = underflow & ~is_cap;
    assign capture   = is_cap & pin_edge;                              // see RULE20

    // ************************************************************
    // Counter and reload register
    // ************************************************************
    // A software byte write wins over counting in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_b_counter <= rtb_pkg::COUNTER_RESET;                 // see RULE19
        end else if (wr_cnt_lo) begin
            timer_b_counter <= {timer_b_counter[15:8], wdata};         // see RULE22
        end else if (wr_cnt_hi) begin
            timer_b_counter <= {wdata, timer_b_counter[7:0]};          // see RULE22
        end else if (reload_uf) begin
            timer_b_counter <= reload_capture_reg;                     // see RULE7
        end else if (tick) begin
            timer_b_counter <= timer_b_counter - rtb_pkg::COUNTER_STEP; // see RULE2
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload_capture_reg <= rtb_pkg::RELOAD_RESET;               // see RULE19
        end else if (wr_rl_lo) begin
            reload_capture_reg <= {reload_capture_reg[15:8], wdata};   // see RULE22
        end else if (wr_rl_hi) begin
            reload_capture_reg <= {wdata, reload_capture_reg[7:0]};    // see RULE22
        end else if (capture) begin
            reload_capture_reg <= timer_b_counter;                     // see RULE20
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Hardware sets of run and pending win over a software clear in the same
    // cycle, so no event is lost while a handler clears the flag.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl.mode    <= rtb_pkg::MODE_RESET;
            ctrl.run     <= 1'b0;
            ctrl.pending <= 1'b0;
            ctrl.irq_en  <= 1'b0;
            ctrl.rsvd    <= rtb_pkg::CTRL_RSVD;
        end else begin
            ctrl.rsvd <= rtb_pkg::CTRL_RSVD;                           // see RULE23
            if (wr_ctrl) begin
                ctrl.mode   <= wctrl.mode;                             // see RULE1
                ctrl.irq_en <= wctrl.irq_en;                           // see RULE5
            end
            ctrl.run <= (wr_ctrl ? wctrl.run : ctrl.run)               // see RULE2
                      | (is_cap & underflow);                          // see RULE3
            ctrl.pending <= (wr_ctrl ? wctrl.pending : ctrl.pending)   // see RULE12
                          | reload_uf                                  // see RULE9
                          | capture;                                   // see RULE20
        end
    end

    // ************************************************************
    // Pin, port registers and global enable
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_direction_reg <= rtb_pkg::PORT_RESET;
        end else if (wr_pdir) begin
            port_direction_reg <= wdata;
        end
    end

    // A software write to the port data wins over a toggle in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_output_reg <= rtb_pkg::PORT_RESET;
        end else if (wr_pout) begin
            port_output_reg <= wdata;
        end else if (reload_uf && ctrl.mode == rtb_pkg::MODE_PWM_TOGGLE) begin
            port_output_reg[rtb_pkg::PIN_BIT] <= ~port_output_reg[rtb_pkg::PIN_BIT]; // see RULE8
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_irq_en <= 1'b0;
        end else if (wr_glob) begin
            global_irq_en <= wdata[rtb_pkg::GLOBAL_EN_BIT];
        end
    end

    assign timer_b_pin_out = port_output_reg[rtb_pkg::PIN_BIT];
    assign timer_b_pin_oe  = port_direction_reg[rtb_pkg::PIN_BIT];

    // In capture mode the run bit is the underflow flag and also requests.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctrl.pending | (is_cap & ctrl.run))                // see RULE10
                 & ctrl.irq_en & global_irq_en;                        // see RULE5
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_ctrl_rsvd_zero: assert property ( // see RULE23
        (rd_pend && req.addr == rtb_pkg::ADDR_CTRL) |=> (hrdata[1:0] == rtb_pkg::CTRL_RSVD))
        else $error("Reserved control bits not read as zero.");

    chk_irq_gate_terms: assert property ( // see RULE10
        ((ctrl.pending | (is_cap & ctrl.run)) & ctrl.irq_en & global_irq_en) |=> irq)
        else $error("Interrupt missing with all gates open.");

    chk_irq_no_enable: assert property (!ctrl.irq_en |=> !irq) // see RULE5
        else $error("Interrupt raised while disabled.");

    chk_pwm_reload_value: assert property ( // see RULE7
        (reload_uf && !wr_cnt_lo && !wr_cnt_hi)
        |=> (timer_b_counter == $past(reload_capture_reg)))
        else $error("Counter not reloaded on underflow.");

    chk_pwm_pin_toggle: assert property ( // see RULE8
        (reload_uf && ctrl.mode == rtb_pkg::MODE_PWM_TOGGLE && !wr_pout)
        |=> (timer_b_pin_out != $past(timer_b_pin_out)))
        else $error("Pin not toggled on underflow.");

    chk_pend_on_reload: assert property (reload_uf |=> ctrl.pending) // see RULE9
        else $error("Pending not set on reload underflow.");

    chk_evt_no_edge: assert property ( // see RULE15
        (is_evt && !pin_edge && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(timer_b_counter))
        else $error("Event counter moved without an edge.");

    chk_stop_holds: assert property ( // see RULE2
        (!is_cap && !ctrl.run && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(timer_b_counter))
        else $error("Stopped counter moved.");

    chk_cap_copy: assert property ( // see RULE20
        (capture && !wr_rl_lo && !wr_rl_hi)
        |=> (reload_capture_reg == $past(timer_b_counter)) && ctrl.pending)
        else $error("Capture did not copy counter or set pending.");

    chk_cap_free_run: assert property ( // see RULE21
        (is_cap && instr_en && !wr_cnt_lo && !wr_cnt_hi)
        |=> (timer_b_counter == 16'($past(timer_b_counter) - 16'h0001)))
        else $error("Capture mode counter did not decrement.");

    chk_cap_uflow_flag: assert property ((is_cap && underflow) |=> ctrl.run) // see RULE3
        else $error("Capture underflow flag not set.");

    chk_instr_pulse: assert property (instr_en |=> !instr_en [*8]) // see RULE23
        else $error("Instruction enable not a single pulse.");

    chk_read_wait: assert property (rd_accept |=> !hreadyout ##1 hreadyout)
        else $error("Read answer timing wrong.");

    cov_pwm_toggle: cover property (reload_uf && ctrl.mode == rtb_pkg::MODE_PWM_TOGGLE);
    cov_evt_uflow:  cover property (is_evt && underflow);
    cov_capture:    cover property (capture);
    cov_irq:        cover property (irq);

endmodule : rtb_timer
